// [include/rsps_map.vh]
// address map, field positions, reset values and counts for the strap and select block
`ifndef RSPS_MAP_VH
`define RSPS_MAP_VH

// configuration bus block
`define RSPS_BLOCK_BASE 32'h01b3_f000
`define RSPS_BLOCK_HI 31
`define RSPS_BLOCK_LO 12
`define RSPS_OFS_PERIPHERAL_SELECT_CTRL 12'h000

// peripheral_select_ctrl fields
`define RSPS_CTRL_W 7
`define RSPS_CTRL_RESET 7'h06
`define RSPS_BIT_VIDEO_PORT2_ENABLE 6
`define RSPS_BIT_VIDEO_PORT1_ENABLE 5
`define RSPS_BIT_VIDEO_PORT0_ENABLE 4
`define RSPS_BIT_TWO_WIRE_UNIT_ENABLE 3
`define RSPS_BIT_SERIAL_PORT1_SELECT 2
`define RSPS_BIT_SERIAL_PORT0_SELECT 1
`define RSPS_BIT_AUDIO_SERIAL_SELECT 0

// strap vector layout
`define RSPS_STRAP_W 10
`define RSPS_STRAP_BYTE_ORDER 0
`define RSPS_STRAP_BOOT_LO 1
`define RSPS_STRAP_BOOT_HI 2
`define RSPS_STRAP_MEMCLK_LO 3
`define RSPS_STRAP_MEMCLK_HI 4
`define RSPS_STRAP_EEPROM 5
`define RSPS_STRAP_PCI_SPEED 6
`define RSPS_STRAP_HP_WIDTH 7
`define RSPS_STRAP_PCI_EN 8
`define RSPS_STRAP_MAC_EN 9
`define RSPS_STRAP_RESET 10'h001

// strap encodings
`define RSPS_BOOT_NONE 2'h0
`define RSPS_BOOT_HOST 2'h1
`define RSPS_BOOT_MEMIF 2'h3
`define RSPS_MEMCLK_EXT 2'h0
`define RSPS_MEMCLK_DIV4 2'h1
`define RSPS_MEMCLK_DIV6 2'h2

// memory-interface clock division counts
`define RSPS_DIV4_COUNT 3'h3
`define RSPS_DIV6_COUNT 3'h5

`endif

// [logic/rsps_strap_latch.v]
// strap capture register, loaded while internal reset is held
`timescale 1ns/10ps

module rsps_strap_latch #(
	parameter WIDTH = 10,
	parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
	// clock and resets
	input wire core_clk,
	input wire reset_n,
	input wire hold_n,
	// strap pins and captured copy
	input wire [WIDTH-1:0] strap_in,
	output reg [WIDTH-1:0] strap_q
);

	// async reset gives defaults; pins are caught on edges while hold_n is low
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			strap_q <= RESET_VALUE;
		end else if (!hold_n) begin
			strap_q <= strap_in;
		end
	end

endmodule // rsps_strap_latch

// [logic/rsps_top.v]
// reset strap capture, strap decoding and peripheral select control register
`timescale 1ns/10ps
`include "rsps_map.vh"

// Overview of operation
// - endian strap: 0 big, 1 little
// - boot strap selects boot source
// - clock strap picks external, div4, div6
// - eeprom autoinit only when pci enabled
// - pci speed strap: 0 66MHz, 1 33MHz
// - width strap: 16 or 32 bit lanes
// - select pair 00 host, 10 pci
// - select 01 enables mac, host narrowed/off
// - registers in 4K block at base
// - bits 31:7 read zero, ignore writes
// - control reset: serial selects set, others clear
// - video port 2 enable bit
// - straps sampled in reset, held after
// - video 1, 0 and i2c enables
// - serial select bits own low video pins
// - audio select owns upper video pins
module rsps_top (
	// clock and reset
	input wire core_clk,
	input wire reset_n,
	// strap pins
	input wire byte_order_strap,
	input wire [1:0] boot_source_strap,
	input wire [1:0] memif_clock_strap,
	input wire pci_eeprom_autoinit_strap,
	input wire pci_speed_strap,
	input wire host_port_width_strap,
	input wire pci_enable_strap,
	input wire mac_enable_strap,
	// configuration bus
	input wire cfg_sel,
	input wire cfg_wr,
	input wire [31:0] cfg_addr,
	input wire [3:0] cfg_be,
	input wire [31:0] cfg_wdata,
	output reg [31:0] cfg_rdata,
	output reg cfg_ready,
	// static settings from straps, and the memory interface clock tick that runs from them
	output wire byte_order_setting,
	output wire boot_none,
	output wire boot_host,
	output wire boot_pci,
	output wire boot_memif,
	output wire boot_reserved,
	output wire memif_clock_ext,
	output wire memif_clock_div4,
	output wire memif_clock_div6,
	output wire memif_clock_reserved,
	output reg memif_clock_tick,
	output wire pci_enable,
	output wire pci_eeprom_autoinit,
	output wire pci_66mhz,
	output wire pci_33mhz,
	output wire host_port_enable,
	output wire host_port_32bit,
	output wire host_port_16bit,
	output wire host_upper_lanes_hiz,
	output wire ethernet_mac_enable,
	output wire mdio_enable,
	output wire gpio_upper_available,
	output wire peripheral_select_reserved,
	// software selected functions
	output wire video_port2_enable,
	output wire video_port1_enable,
	output wire video_port0_enable,
	output wire two_wire_unit_enable,
	output wire video_port1_low_pins,
	output wire video_port0_low_pins,
	output wire serial_port1_enable,
	output wire serial_port0_enable,
	output wire video_port1_upper_pins,
	output wire video_port0_upper_pins,
	output wire multichannel_audio_port_enable
);

	// one-hot decode of a two-bit strap field
	function [3:0] dec2;
		input [1:0] code;
		begin
			dec2 = 4'h0;
			dec2[code] = 1'b1;
		end
	endfunction

	// a shared pin reaches its video port only when enabled and not claimed
	function pin_to_video;
		input port_enable;
		input claimed;
		begin
			pin_to_video = port_enable & ~claimed;
		end
	endfunction

	// reset release synchroniser
	reg rst_meta_n;
	reg rst_sync_n;

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end

	// strap capture
	wire [`RSPS_STRAP_W-1:0] strap_pins;
	wire [`RSPS_STRAP_W-1:0] strap;

	assign strap_pins = {
		mac_enable_strap,
		pci_enable_strap,
		host_port_width_strap,
		pci_speed_strap,
		pci_eeprom_autoinit_strap,
		memif_clock_strap,
		boot_source_strap,
		byte_order_strap
	};

	rsps_strap_latch #(
		.WIDTH(`RSPS_STRAP_W),
		.RESET_VALUE(`RSPS_STRAP_RESET)
	) u_strap_latch (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.hold_n(rst_sync_n),
		.strap_in(strap_pins),
		.strap_q(strap)
	);

	// strap fields
	wire pci_sel;
	wire mac_sel;
	wire width_32;
	wire [3:0] boot_dec;
	wire [3:0] clk_dec;

	assign pci_sel = strap[`RSPS_STRAP_PCI_EN];
	assign mac_sel = strap[`RSPS_STRAP_MAC_EN];
	assign width_32 = strap[`RSPS_STRAP_HP_WIDTH];
	assign boot_dec = dec2(strap[`RSPS_STRAP_BOOT_HI:`RSPS_STRAP_BOOT_LO]);
	assign clk_dec = dec2(strap[`RSPS_STRAP_MEMCLK_HI:`RSPS_STRAP_MEMCLK_LO]);

	// byte order: 1 little, 0 big
	assign byte_order_setting = strap[`RSPS_STRAP_BYTE_ORDER];

	// boot source
	assign boot_none = boot_dec[`RSPS_BOOT_NONE];
	assign boot_host = boot_dec[`RSPS_BOOT_HOST] & ~pci_sel;
	assign boot_pci = boot_dec[`RSPS_BOOT_HOST] & pci_sel;
	assign boot_memif = boot_dec[`RSPS_BOOT_MEMIF];
	assign boot_reserved = boot_dec[2];

	// memory interface clock source
	assign memif_clock_ext = clk_dec[`RSPS_MEMCLK_EXT];
	assign memif_clock_div4 = clk_dec[`RSPS_MEMCLK_DIV4];
	assign memif_clock_div6 = clk_dec[`RSPS_MEMCLK_DIV6];
	assign memif_clock_reserved = clk_dec[3];

	// core clock divider for the memory interface clock enable
	reg [2:0] div_count;
	reg [2:0] next_div_count;
	reg next_memif_clock_tick;
	wire [2:0] div_limit;
	wire div_run;

	assign div_limit = memif_clock_div6 ? `RSPS_DIV6_COUNT : `RSPS_DIV4_COUNT;
	assign div_run = memif_clock_div4 | memif_clock_div6;

	always @* begin
		next_div_count = 3'h0;
		next_memif_clock_tick = 1'b0;
		if (div_run && rst_sync_n) begin
			if (div_count == div_limit) begin
				next_memif_clock_tick = 1'b1;
			end else begin
				next_div_count = div_count + 3'h1;
			end
		end
	end

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			div_count <= 3'h0;
			memif_clock_tick <= 1'b0;
		end else begin
			div_count <= next_div_count;
			memif_clock_tick <= next_memif_clock_tick;
		end
	end

	// peripheral selection from the pci / mac strap pair
	wire sel_host;
	wire sel_mac;
	wire sel_pci;

	assign sel_host = ~pci_sel & ~mac_sel;
	assign sel_mac = ~pci_sel & mac_sel;
	assign sel_pci = pci_sel & ~mac_sel;
	assign peripheral_select_reserved = pci_sel & mac_sel;

	assign pci_enable = sel_pci;
	assign pci_eeprom_autoinit = sel_pci & strap[`RSPS_STRAP_EEPROM];
	assign pci_66mhz = sel_pci & ~strap[`RSPS_STRAP_PCI_SPEED];
	assign pci_33mhz = sel_pci & strap[`RSPS_STRAP_PCI_SPEED];

	// host port: full width only when selected alone with the wide strap
	assign host_port_enable = sel_host | (sel_mac & ~width_32);
	assign host_port_32bit = sel_host & width_32;
	assign host_port_16bit = host_port_enable & ~width_32;
	assign host_upper_lanes_hiz = ~host_port_32bit & ~sel_mac;
	assign ethernet_mac_enable = sel_mac;
	assign mdio_enable = sel_mac;
	assign gpio_upper_available = ~pci_sel;

	// peripheral_select_ctrl register and bus slave
	// block page and register offset as sliceable constants
	localparam [31:0] BLOCK_BASE = `RSPS_BLOCK_BASE;
	localparam [`RSPS_BLOCK_HI-`RSPS_BLOCK_LO:0] BLOCK_PAGE =
		BLOCK_BASE[`RSPS_BLOCK_HI:`RSPS_BLOCK_LO];
	localparam [`RSPS_BLOCK_LO-1:0] CTRL_OFS = `RSPS_OFS_PERIPHERAL_SELECT_CTRL;

	reg [`RSPS_CTRL_W-1:0] ctrl;
	reg [`RSPS_CTRL_W-1:0] next_ctrl;
	reg [31:0] next_rdata;
	wire in_block;
	wire hit_ctrl;
	wire take;

	assign in_block = cfg_addr[`RSPS_BLOCK_HI:`RSPS_BLOCK_LO] ==
		BLOCK_PAGE;
	assign hit_ctrl = in_block &&
		(cfg_addr[`RSPS_BLOCK_LO-1:0] == CTRL_OFS);
	assign take = cfg_sel & in_block & rst_sync_n;

	always @* begin
		next_ctrl = ctrl;
		next_rdata = cfg_rdata;
		if (take && hit_ctrl && cfg_wr && cfg_be[0]) begin
			next_ctrl = cfg_wdata[`RSPS_CTRL_W-1:0];
		end
		if (take && !cfg_wr) begin
			next_rdata = 32'h0000_0000;
			if (hit_ctrl) begin
				next_rdata[`RSPS_CTRL_W-1:0] = ctrl;
			end
		end
	end

	// control register: back to defaults while the internal reset is held
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl <= `RSPS_CTRL_RESET;
		end else if (!rst_sync_n) begin
			ctrl <= `RSPS_CTRL_RESET;
		end else begin
			ctrl <= next_ctrl;
		end
	end

	// bus answer and read data
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg_rdata <= 32'h0000_0000;
			cfg_ready <= 1'b0;
		end else if (!rst_sync_n) begin
			cfg_rdata <= 32'h0000_0000;
			cfg_ready <= 1'b0;
		end else begin
			cfg_rdata <= next_rdata;
			cfg_ready <= take;
		end
	end

	// software selected enables, straight from the register
	assign video_port2_enable = ctrl[`RSPS_BIT_VIDEO_PORT2_ENABLE];
	assign video_port1_enable = ctrl[`RSPS_BIT_VIDEO_PORT1_ENABLE];
	assign video_port0_enable = ctrl[`RSPS_BIT_VIDEO_PORT0_ENABLE];
	assign two_wire_unit_enable = ctrl[`RSPS_BIT_TWO_WIRE_UNIT_ENABLE];

	// shared low video pins versus buffered serial ports
	assign serial_port1_enable = ctrl[`RSPS_BIT_SERIAL_PORT1_SELECT];
	assign serial_port0_enable = ctrl[`RSPS_BIT_SERIAL_PORT0_SELECT];
	assign video_port1_low_pins = pin_to_video(video_port1_enable, serial_port1_enable);
	assign video_port0_low_pins = pin_to_video(video_port0_enable, serial_port0_enable);

	// shared upper video pins versus multichannel audio port
	assign multichannel_audio_port_enable = ctrl[`RSPS_BIT_AUDIO_SERIAL_SELECT];
	assign video_port1_upper_pins = pin_to_video(video_port1_enable,
		multichannel_audio_port_enable);
	assign video_port0_upper_pins = pin_to_video(video_port0_enable,
		multichannel_audio_port_enable);

	// all pin selects above are combinational from ctrl and straps
	// glitch-free switching relies on software leaving affected units idle

endmodule // rsps_top

// [verif/rsps_checker.sv]
// port assertions for the strap and select block
`timescale 1ns/10ps
module rsps_checker (
	// clock and reset
	input wire core_clk,
	input wire reset_n,
	// configuration bus
	input wire cfg_sel,
	input wire cfg_wr,
	input wire [31:0] cfg_addr,
	input wire [3:0] cfg_be,
	input wire [31:0] cfg_wdata,
	input wire [31:0] cfg_rdata,
	input wire cfg_ready,
	// decoded outputs
	input wire byte_order_setting,
	input wire pci_enable,
	input wire host_port_enable,
	input wire host_port_32bit,
	input wire host_upper_lanes_hiz,
	input wire ethernet_mac_enable,
	input wire mdio_enable,
	input wire video_port2_enable,
	input wire video_port1_enable,
	input wire video_port0_enable,
	input wire serial_port0_enable,
	input wire multichannel_audio_port_enable,
	input wire video_port0_low_pins,
	input wire video_port1_upper_pins
);
	reg [1:0] rcnt;
	wire live = rcnt[1];
	wire hit = cfg_sel && cfg_addr[31:12] == 20'h0_1b3f;
	// cycles since reset release, saturating
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			rcnt <= 2'h0;
		else if (rcnt != 2'h3)
			rcnt <= rcnt + 2'h1;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	a_ready_hit: assert property (live && hit |=> cfg_ready)
		else $error("no answer to block access");
	a_miss_quiet: assert property (live && cfg_sel && !hit |=> !cfg_ready)
		else $error("answer outside block");
	a_rdata_zero: assert property (cfg_ready |-> cfg_rdata[31:7] == 25'h000_0000)
		else $error("reserved bits not zero");
	a_vp2_write: assert property (live && hit && cfg_wr && cfg_be[0] &&
		cfg_addr[11:0] == 12'h000 |=> video_port2_enable == $past(cfg_wdata[6]))
		else $error("video port 2 enable not updated");
	a_straps_held: assert property (rcnt == 2'h3 |->
		$stable(byte_order_setting) && $stable(pci_enable))
		else $error("strap setting changed");
	a_low_pins: assert property (video_port0_low_pins == (video_port0_enable && !serial_port0_enable))
		else $error("low pin select wrong");
	a_upper_pins: assert property (video_port1_upper_pins ==
		(video_port1_enable && !multichannel_audio_port_enable))
		else $error("upper pin select wrong");
	a_wide_host: assert property (host_port_32bit |-> host_port_enable && !host_upper_lanes_hiz)
		else $error("wide host lanes wrong");
	a_mac_excl: assert property (ethernet_mac_enable |->
		mdio_enable && !pci_enable && !host_port_32bit)
		else $error("mac select wrong");
	c_write: cover property (live && hit && cfg_wr);
	c_mac: cover property (ethernet_mac_enable);
	c_wide: cover property (host_port_32bit);
endmodule // rsps_checker

bind rsps_top rsps_checker u_rsps_checker (.*);

// [verif/rsps_strap_board.sv]
// board strap resistors: levels in reset, pins reused afterwards
`timescale 1ns/10ps
module rsps_strap_board (
	// clock and reset
	input wire core_clk,
	input wire reset_n,
	// chosen strap levels
	input wire [9:0] strap_cfg,
	// strap pins
	output wire byte_order_strap,
	output wire [1:0] boot_source_strap,
	output wire [1:0] memif_clock_strap,
	output wire pci_eeprom_autoinit_strap,
	output wire pci_speed_strap,
	output wire host_port_width_strap,
	output wire pci_enable_strap,
	output wire mac_enable_strap
);
	reg [2:0] age;
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			age <= 3'h0;
		else if (age != 3'h7)
			age <= age + 3'h1;
	end
	// pins show other traffic once the capture window is over
	assign {mac_enable_strap, pci_enable_strap, host_port_width_strap, pci_speed_strap,
		pci_eeprom_autoinit_strap, memif_clock_strap, boot_source_strap, byte_order_strap}
		= (age < 3'h4) ? strap_cfg : ~strap_cfg;
endmodule // rsps_strap_board

// [verif/rsps_top_tb.sv]
// self-checking bench for the strap and select block
`timescale 1ns/10ps
module rsps_top_tb;
	reg core_clk = 1'b0;
	reg reset_n = 1'b0;
	reg cfg_sel = 1'b0;
	reg cfg_wr = 1'b0;
	reg [31:0] cfg_addr = 32'h0000_0000;
	reg [3:0] cfg_be = 4'h0;
	reg [31:0] cfg_wdata = 32'h0000_0000;
	reg [9:0] strap_cfg = 10'h001;
	wire [31:0] cfg_rdata;
	wire [1:0] boot_source_strap, memif_clock_strap;
	wire cfg_ready, byte_order_strap, pci_eeprom_autoinit_strap, pci_speed_strap;
	wire host_port_width_strap, pci_enable_strap, mac_enable_strap, byte_order_setting;
	wire boot_none, boot_host, boot_pci, boot_memif, boot_reserved, memif_clock_ext;
	wire memif_clock_div4, memif_clock_div6, memif_clock_reserved, memif_clock_tick;
	wire pci_enable, pci_eeprom_autoinit, pci_66mhz, pci_33mhz, host_port_enable;
	wire host_port_32bit, host_port_16bit, host_upper_lanes_hiz, ethernet_mac_enable;
	wire mdio_enable, gpio_upper_available, peripheral_select_reserved, video_port2_enable;
	wire video_port1_enable, video_port0_enable, two_wire_unit_enable, video_port1_low_pins;
	wire video_port0_low_pins, serial_port1_enable, serial_port0_enable;
	wire video_port1_upper_pins, video_port0_upper_pins, multichannel_audio_port_enable;
	logic [32:0] q[$];
	logic [32:0] e;
	logic [31:0] w;
	logic [9:0] s;
	logic pci, mac, hen, h32;
	int miscompares = 0;
	int n_checks = 0;
	rsps_top u_rsps_top (.*);
	rsps_strap_board u_rsps_strap_board (.*);
	always #5 core_clk = ~core_clk;
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		n_checks++;
		if (seen !== want) begin
			miscompares++;
			$display("[FAIL] %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic op(input logic wr, input logic [31:0] a, input logic [3:0] be,
		input logic [31:0] d, input logic [32:0] want);
		@(posedge core_clk);
		cfg_sel <= 1'b1;
		cfg_wr <= wr;
		cfg_addr <= a;
		cfg_be <= be;
		cfg_wdata <= d;
		if (a[31:12] == 20'h0_1b3f)
			q.push_back(want);
		@(posedge core_clk);
		cfg_sel <= 1'b0;
	endtask
	task automatic drain;
		int i;
		for (i = 0; i < 20 && q.size() != 0; i++)
			@(posedge core_clk);
		if (q.size() != 0) begin
			miscompares++;
			complete_run();
		end else begin
			repeat (2) @(posedge core_clk);
		end
	endtask
	task automatic boot(input logic [9:0] v);
		reset_n <= 1'b0;
		strap_cfg <= v;
		repeat (5) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (6) @(posedge core_clk);
	endtask
	task automatic check_sel(input logic [6:0] x);
		chk({video_port2_enable, video_port1_enable, video_port0_enable, two_wire_unit_enable,
			serial_port1_enable, serial_port0_enable, multichannel_audio_port_enable}, x);
		chk({video_port1_low_pins, video_port0_low_pins, video_port1_upper_pins,
			video_port0_upper_pins}, {x[5] & ~x[2], x[4] & ~x[1], x[5] & ~x[0], x[4] & ~x[0]});
	endtask
	// read answers in request order
	always @(posedge core_clk) begin
		if (cfg_ready === 1'b1) begin
			if (q.size() == 0)
				chk(32'h0000_0001, 32'h0000_0000);
			else begin
				e = q.pop_front();
				if (e[32])
					chk(cfg_rdata, e[31:0]);
			end
		end
	end
	initial begin
		int k, t;
		logic [31:0] n;
		void'($urandom(39));
		for (k = 0; k < 8; k++) begin
			w = $urandom;
			s = w[9:0];
			s[9:8] = k[1:0];
			s[7:5] = {k[2], k[2], ~k[2]};
			s[4:3] = k[1:0];
			s[2:1] = k[2:1];
			boot(s);
			pci = s[9:8] == 2'b01;
			mac = s[9:8] == 2'b10;
			h32 = s[9:8] == 2'b00 && s[7];
			hen = s[9:8] == 2'b00 || (mac && !s[7]);
			chk({byte_order_setting, boot_none, boot_host, boot_pci, boot_memif, boot_reserved},
				{s[0], s[2:1] == 2'b00, s[2:1] == 2'b01 && !s[8], s[2:1] == 2'b01 && s[8],
				s[2:1] == 2'b11, s[2:1] == 2'b10});
			chk({memif_clock_ext, memif_clock_div4, memif_clock_div6, memif_clock_reserved},
				{s[4:3] == 2'b00, s[4:3] == 2'b01, s[4:3] == 2'b10, s[4:3] == 2'b11});
			chk({pci_enable, pci_eeprom_autoinit, pci_66mhz, pci_33mhz},
				{pci, pci && s[5], pci && !s[6], pci && s[6]});
			chk({host_port_enable, host_port_32bit, host_port_16bit, host_upper_lanes_hiz,
				ethernet_mac_enable, mdio_enable, peripheral_select_reserved, gpio_upper_available},
				{hen, h32, hen && !s[7], !(h32 || mac), mac, mac, s[9:8] == 2'b11, !s[8]});
			n = 32'h0000_0000;
			for (t = 0; t < 24; t++) begin
				@(posedge core_clk);
				n = n + memif_clock_tick;
			end
			chk(n, (s[4:3] == 2'b01) ? 32'h0000_0006 : (s[4:3] == 2'b10) ? 32'h0000_0004
				: 32'h0000_0000);
			op(1'b0, 32'h01b3_f000, 4'hf, 32'h0000_0000, {1'b1, 32'h0000_0006});
			drain();
			check_sel(7'h06);
			w = $urandom;
			op(1'b1, 32'h01b3_f000, 4'h1, w, 33'h0);
			op(1'b1, 32'h01b3_f000, 4'h0, ~w, 33'h0);
			op(1'b1, 32'h01b3_f004, 4'hf, ~w, 33'h0);
			op(1'b1, 32'h01b4_0000, 4'hf, ~w, 33'h0);
			op(1'b0, 32'h01b3_f000, 4'hf, 32'h0000_0000, {1'b1, 25'h0, w[6:0]});
			op(1'b0, 32'h01b3_f008, 4'hf, 32'h0000_0000, {1'b1, 32'h0000_0000});
			drain();
			check_sel(w[6:0]);
			$display("test %0d done", k);
		end
		complete_run();
	end
endmodule // rsps_top_tb
